// ==== pdr_pkg.sv ====
package pdr_pkg;
    // ==========================================================
    // sizes
    localparam int XLEN = 32;
    localparam int NARCH = 8;
    localparam int REG_W = 3;
    localparam int ROB_N = 16;
    localparam int ROB_W = 4;
    localparam int ISSUE = 4;
    localparam int NUNIT = 6;
    localparam int RS_PER = 2;
    localparam int INS_MAX = 15;
    localparam int QBYTES = 32;
    localparam int UCODE_OPS = 8;
    localparam int REC_CYC = 3;
    localparam int PRED_N = 1024;
    localparam int PRED_W = 10;
    localparam int LINE_B = 4;
    localparam int FIFO_D = 4;
    // ==========================================================
    // predecode tag: start, end, opcode, op count (0 = microcode)
    localparam int T_ST = 4;
    localparam int T_EN = 3;
    localparam int T_OP = 2;
    localparam int T_CNT = 0;
    localparam int CNT_W = 2;
    localparam logic [1:0] CNT_UCODE = 2'h0;
    localparam logic [7:0] PREFIX = 8'h66;
    // ==========================================================
    // carriers
    typedef logic [ROB_W-1:0] pdr_rtag_t;
    typedef struct packed {logic [7:0] b; logic [4:0] tag;} pdr_tbyte_t;
    typedef struct packed {logic [3:0] len; pdr_tbyte_t [INS_MAX-1:0] by;} pdr_ins_t;
    typedef struct packed {logic rdy; pdr_rtag_t tag; logic [XLEN-1:0] val;} pdr_opnd_t;
    typedef struct packed {
        logic v; logic [7:0] opc; pdr_rtag_t rob; pdr_opnd_t a; pdr_opnd_t b;
    } pdr_rs_t;
    typedef struct packed {
        logic v; logic [7:0] opc; pdr_rtag_t rob; logic [XLEN-1:0] a; logic [XLEN-1:0] b;
    } pdr_iss_t;
    typedef struct packed {
        logic v; pdr_rtag_t rob; logic [XLEN-1:0] data;
        logic mis; logic taken; logic [XLEN-1:0] bpc; logic [XLEN-1:0] tgt;
    } pdr_res_t;
    typedef struct packed {logic v; logic [REG_W-1:0] rg; logic [XLEN-1:0] data;} pdr_ret_t;
    typedef struct packed {logic v; pdr_rtag_t rob;} pdr_kill_t;
endpackage : pdr_pkg

// ==== pdr_core.sv ====
// Operation
// - tag every code byte with start and end marks, lengths 8 to 120 bits
// - tags also mark the opcode byte and the op count
// - byte queue holds fetched bytes with their tags until decode takes them
// - one instruction of up to 15 tagged bytes passes queue to decoder per cycle, in order
// - decode position chosen from the 5-bit tag, op count reused not recomputed
// - under four ops goes straight to the fast decode positions
// - four or more ops come from the microcode ROM path instead
// - up to four per cycle issue into decode and dispatch
// - dispatch in parallel to six units, two stations each
// - stations filled in program order, each releases independently
// - station holds op until unit free and operands ready
// - a unit that finishes takes the next ready op from its stations
// - sources read at decode from register file or pending reorder entry
// - reorder buffer renames, forwards, recovers and holds speculative state
// - reorder buffer has 16 entries
// - one entry per op allocated at the top, at most four a cycle
// - results retire strictly in order and write the register file
// - wrong-path entries invalidated before touching architectural state
// - per line predicted target of first taken branch, 1024 targets
// - mispredict recovery costs at least three cycles before refetch
`timescale 1ns/100ps
// ==========================================================
// byte queue fifo; depth must be a power of two
module pdr_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] n_q;
    logic push, pop;
    assign in_ready = n_q != (AW+1)'(D);
    assign out_valid = n_q != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rp_q];
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            n_q <= '0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            n_q <= '0;
        end else begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(pop);
            n_q <= n_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push && !flush) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : pdr_fifo
// ==========================================================
module pdr_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // fetch
    output logic fetch_req,
    output logic [pdr_pkg::XLEN-1:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    output logic fetch_ready,
    // register file
    input wire logic [pdr_pkg::NARCH-1:0][pdr_pkg::XLEN-1:0] rf_data,
    output pdr_pkg::pdr_ret_t ret_o,
    // execution units
    input wire logic [pdr_pkg::NUNIT-1:0] unit_free,
    output pdr_pkg::pdr_iss_t [pdr_pkg::NUNIT-1:0] iss_o,
    input wire pdr_pkg::pdr_res_t [pdr_pkg::NUNIT-1:0] res_i,
    output pdr_pkg::pdr_kill_t kill_o
);
    import pdr_pkg::*;
    // ==========================================================
    // state
    logic [3:0] idx_q, len_q, mstep_q;
    logic [1:0] cnt_q, rec_q;
    logic pfx_q;
    pdr_tbyte_t [INS_MAX-1:0] asm_q;
    logic [PRED_N-1:0] pred_v_q;
    logic [XLEN-1:0] pred_t_q [PRED_N];
    logic [ROB_N-1:0] rob_v_q, rob_d_q, rob_w_q;
    logic [REG_W-1:0] rob_r_q [ROB_N];
    logic [XLEN-1:0] rob_val_q [ROB_N];
    pdr_rtag_t head_q, tail_q;
    logic [ROB_W:0] rcnt_q;
    logic [NARCH-1:0] ren_p_q;
    pdr_rtag_t ren_t_q [NARCH];
    pdr_rs_t rs_q [NUNIT][RS_PER];
    // ==========================================================
    // helpers
    function automatic pdr_rtag_t f_age(input pdr_rtag_t x);
        return x - head_q;
    endfunction : f_age
    function automatic logic [3:0] f_len(input logic [7:0] b);
        return (b[3:0] == 4'h0) ? 4'h1 : b[3:0];
    endfunction : f_len
    function automatic logic [2:0] f_unit(input logic [7:0] opc, input logic [2:0] k);
        logic [3:0] s;
        s = {1'b0, opc[2:0]} + {1'b0, k};
        return (s >= 4'(NUNIT)) ? 3'(s - 4'(NUNIT)) : s[2:0];
    endfunction : f_unit
    function automatic pdr_opnd_t f_fwd(input pdr_opnd_t o);
        pdr_opnd_t r;
        r = o;
        for (int u = 0; u < NUNIT; u++) begin
            if (!o.rdy && res_i[u].v && res_i[u].rob == o.tag) begin
                r.rdy = 1'b1;
                r.val = res_i[u].data;
            end
        end
        return r;
    endfunction : f_fwd
    function automatic pdr_opnd_t f_src(input logic [REG_W-1:0] g);
        pdr_opnd_t r;
        r = '{rdy: 1'b1, tag: ren_t_q[g], val: rf_data[g]};
        // the register file takes a retired value one edge late
        if (ret_o.v && ret_o.rg == g) begin
            r.val = ret_o.data;
        end
        if (ren_p_q[g]) begin
            r.rdy = rob_d_q[ren_t_q[g]];
            r.val = rob_val_q[ren_t_q[g]];
        end
        return f_fwd(r);
    endfunction : f_src
    // ==========================================================
    // mispredict pick: oldest flagged branch of this cycle
    logic mis_now, flush, retire;
    pdr_res_t mis_res;
    always_comb begin
        mis_now = 1'b0;
        mis_res = '0;
        for (int u = 0; u < NUNIT; u++) begin
            if (res_i[u].v && res_i[u].mis && rob_v_q[res_i[u].rob] &&
                (!mis_now || f_age(res_i[u].rob) < f_age(mis_res.rob))) begin
                mis_now = 1'b1;
                mis_res = res_i[u];
            end
        end
    end
    assign flush = mis_now || rec_q != '0;
    assign fetch_req = rec_q == '0;
    // ==========================================================
    // predecoder
    logic is_pfx, opc_now, end_now, take_b, q_in_ready, q_out_valid, q_pop;
    logic [3:0] len_now, lraw;
    logic [1:0] cnt_now;
    pdr_tbyte_t tb;
    pdr_ins_t q_in, q_out;
    always_comb begin
        is_pfx = idx_q == '0 && fetch_byte == PREFIX;
        opc_now = (idx_q == '0 && !is_pfx) || (idx_q == 4'h1 && pfx_q);
        lraw = f_len(fetch_byte);
        len_now = len_q;
        if (opc_now) begin
            len_now = (pfx_q && lraw != 4'(INS_MAX)) ? lraw + 4'h1 : lraw;
        end
        cnt_now = opc_now ? fetch_byte[5:4] : cnt_q;
        end_now = !is_pfx && idx_q == len_now - 4'h1;
        tb.b = fetch_byte;
        tb.tag = {idx_q == '0, end_now, opc_now, cnt_now};
        q_in.len = len_now;
        q_in.by = asm_q;
        q_in.by[idx_q] = tb;
    end
    // a full queue holds back only the closing byte
    assign fetch_ready = !flush && (!end_now || q_in_ready);
    assign take_b = fetch_valid && fetch_ready;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idx_q <= '0;
            pfx_q <= 1'b0;
            len_q <= '0;
            cnt_q <= '0;
            asm_q <= '0;
        end else if (mis_now) begin
            idx_q <= '0;
            pfx_q <= 1'b0;
        end else if (take_b) begin
            asm_q[idx_q] <= tb;
            len_q <= len_now;
            cnt_q <= cnt_now;
            idx_q <= end_now ? '0 : idx_q + 4'h1;
            pfx_q <= is_pfx;
        end
    end
    // ==========================================================
    // fetch address and branch target predictor
    logic [PRED_W-1:0] pidx, bidx;
    assign pidx = fetch_addr[LINE_B+:PRED_W];
    assign bidx = mis_res.bpc[LINE_B+:PRED_W];
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fetch_addr <= '0;
            pred_v_q <= '0;
        end else begin
            if (take_b) begin
                // leaving a line: follow its first predicted-taken target
                if (fetch_addr[LINE_B-1:0] == '1 && pred_v_q[pidx]) begin
                    fetch_addr <= pred_t_q[pidx];
                end else begin
                    fetch_addr <= fetch_addr + 32'h1;
                end
            end
            if (mis_now) begin
                fetch_addr <= mis_res.tgt;
                pred_v_q[bidx] <= mis_res.taken;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (mis_now) begin
            pred_t_q[bidx] <= mis_res.tgt;
        end
    end
    // ==========================================================
    // byte queue
    pdr_fifo #(.W($bits(pdr_ins_t)), .D(FIFO_D)) u_bq (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .flush(mis_now),
        .in_valid(fetch_valid && end_now && !flush),
        .in_ready(q_in_ready),
        .in_data(q_in),
        .out_valid(q_out_valid),
        .out_ready(q_pop),
        .out_data(q_out)
    );
    // ==========================================================
    // decode and dispatch
    logic [3:0] opos, remain;
    logic [7:0] opc, modrm;
    logic [1:0] cnt;
    logic microcode_rom_path, last_grp, unit_ok, disp_go;
    logic [2:0] disp_n;
    logic [2:0] u_k [ISSUE];
    logic [ROB_W:0] rob_free;
    pdr_opnd_t opa, opb;
    assign rob_free = (ROB_W+1)'(ROB_N) - rcnt_q;
    always_comb begin
        opos = '0;
        for (int i = INS_MAX - 1; i >= 0; i--) begin
            if (q_out.by[i].tag[T_OP] && 4'(i) < q_out.len) begin
                opos = 4'(i);
            end
        end
        opc = q_out.by[opos].b;
        cnt = q_out.by[opos].tag[T_CNT+:CNT_W];
        modrm = 8'h00;
        if (opos < 4'(INS_MAX - 1) && opos + 4'h1 < q_out.len) begin
            modrm = q_out.by[opos + 4'h1].b;
        end
        microcode_rom_path = cnt == CNT_UCODE;
        remain = 4'(UCODE_OPS) - mstep_q;
        last_grp = !microcode_rom_path || remain <= 4'(ISSUE);
        disp_n = {1'b0, cnt};
        if (microcode_rom_path) begin
            disp_n = last_grp ? remain[2:0] : 3'(ISSUE);
        end
        unit_ok = 1'b1;
        for (int k = 0; k < ISSUE; k++) begin
            u_k[k] = f_unit(opc, 3'(k));
            if (3'(k) < disp_n && rs_q[u_k[k]][0].v && rs_q[u_k[k]][1].v) begin
                unit_ok = 1'b0;
            end
        end
        disp_go = q_out_valid && !flush && unit_ok &&
                  rob_free >= (ROB_W+1)'(disp_n);
        opa = f_src(modrm[2:0]);
        opb = f_src(modrm[5:3]);
    end
    assign q_pop = disp_go && last_grp;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mstep_q <= '0;
        end else if (mis_now || q_pop) begin
            mstep_q <= '0;
        end else if (disp_go) begin
            mstep_q <= mstep_q + 4'(ISSUE);
        end
    end
    // ==========================================================
    // reservation stations and issue
    logic [RS_PER-1:0] sel [NUNIT];
    always_comb begin
        for (int u = 0; u < NUNIT; u++) begin
            logic r0, r1;
            r0 = rs_q[u][0].v && rs_q[u][0].a.rdy && rs_q[u][0].b.rdy;
            r1 = rs_q[u][1].v && rs_q[u][1].a.rdy && rs_q[u][1].b.rdy;
            sel[u][1] = unit_free[u] && !mis_now && r1 &&
                        (!r0 || f_age(rs_q[u][1].rob) < f_age(rs_q[u][0].rob));
            sel[u][0] = unit_free[u] && !mis_now && r0 && !sel[u][1];
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int u = 0; u < NUNIT; u++) begin
                iss_o[u] <= '0;
                for (int s = 0; s < RS_PER; s++) begin
                    rs_q[u][s] <= '0;
                end
            end
        end else begin
            for (int u = 0; u < NUNIT; u++) begin
                iss_o[u].v <= 1'b0;
                for (int s = 0; s < RS_PER; s++) begin
                    rs_q[u][s].a <= f_fwd(rs_q[u][s].a);
                    rs_q[u][s].b <= f_fwd(rs_q[u][s].b);
                    if (sel[u][s]) begin
                        rs_q[u][s].v <= 1'b0;
                        iss_o[u] <= '{v: 1'b1, opc: rs_q[u][s].opc, rob: rs_q[u][s].rob,
                                      a: rs_q[u][s].a.val, b: rs_q[u][s].b.val};
                    end
                    if (mis_now && f_age(rs_q[u][s].rob) > f_age(mis_res.rob)) begin
                        rs_q[u][s].v <= 1'b0;
                    end
                end
            end
            for (int k = 0; k < ISSUE; k++) begin
                if (disp_go && 3'(k) < disp_n) begin
                    // units of one group are distinct, so slots never collide
                    rs_q[u_k[k]][rs_q[u_k[k]][0].v] <= '{v: 1'b1, opc: opc,
                        rob: tail_q + ROB_W'(k), a: opa, b: opb};
                end
            end
        end
    end
    // ==========================================================
    // reorder buffer
    logic [ROB_W:0] rcnt_d;
    assign retire = rob_v_q[head_q] && rob_d_q[head_q];
    always_comb begin
        rcnt_d = rcnt_q + (disp_go ? (ROB_W+1)'(disp_n) : '0) - (ROB_W+1)'(retire);
        if (mis_now) begin
            rcnt_d = (ROB_W+1)'(f_age(mis_res.rob)) + 5'h1 - (ROB_W+1)'(retire);
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rob_v_q <= '0;
            rob_d_q <= '0;
            rob_w_q <= '0;
            head_q <= '0;
            tail_q <= '0;
            rcnt_q <= '0;
            ret_o <= '0;
            kill_o <= '0;
        end else begin
            rcnt_q <= rcnt_d;
            ret_o <= '{v: retire && rob_w_q[head_q], rg: rob_r_q[head_q],
                       data: rob_val_q[head_q]};
            kill_o <= '{v: mis_now, rob: mis_res.rob};
            if (retire) begin
                rob_v_q[head_q] <= 1'b0;
                head_q <= head_q + 4'h1;
            end
            for (int u = 0; u < NUNIT; u++) begin
                if (res_i[u].v && rob_v_q[res_i[u].rob]) begin
                    rob_d_q[res_i[u].rob] <= 1'b1;
                    rob_val_q[res_i[u].rob] <= res_i[u].data;
                end
            end
            for (int k = 0; k < ISSUE; k++) begin
                if (disp_go && 3'(k) < disp_n) begin
                    rob_v_q[tail_q + ROB_W'(k)] <= 1'b1;
                    rob_d_q[tail_q + ROB_W'(k)] <= 1'b0;
                    rob_w_q[tail_q + ROB_W'(k)] <= last_grp && 3'(k) == disp_n - 3'h1;
                    rob_r_q[tail_q + ROB_W'(k)] <= modrm[5:3];
                end
            end
            if (disp_go) begin
                tail_q <= tail_q + ROB_W'(disp_n);
            end
            if (mis_now) begin
                for (int i = 0; i < ROB_N; i++) begin
                    if (f_age(ROB_W'(i)) > f_age(mis_res.rob)) begin
                        rob_v_q[i] <= 1'b0;
                    end
                end
                tail_q <= mis_res.rob + 4'h1;
            end
        end
    end
    // ==========================================================
    // rename map; rebuilt from surviving entries after a mispredict
    logic [NARCH-1:0] rb_p;
    pdr_rtag_t rb_t [NARCH];
    always_comb begin
        for (int g = 0; g < NARCH; g++) begin
            rb_p[g] = 1'b0;
            rb_t[g] = '0;
            for (int a = 0; a < ROB_N; a++) begin
                if (ROB_W'(a) <= f_age(mis_res.rob) && !(retire && a == 0) &&
                    rob_v_q[head_q + ROB_W'(a)] && rob_w_q[head_q + ROB_W'(a)] &&
                    rob_r_q[head_q + ROB_W'(a)] == REG_W'(g)) begin
                    rb_p[g] = 1'b1;
                    rb_t[g] = head_q + ROB_W'(a);
                end
            end
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ren_p_q <= '0;
            for (int g = 0; g < NARCH; g++) begin
                ren_t_q[g] <= '0;
            end
        end else if (mis_now) begin
            ren_p_q <= rb_p;
            ren_t_q <= rb_t;
        end else begin
            if (retire && ren_t_q[rob_r_q[head_q]] == head_q) begin
                ren_p_q[rob_r_q[head_q]] <= 1'b0;
            end
            if (disp_go && last_grp) begin
                ren_p_q[modrm[5:3]] <= 1'b1;
                ren_t_q[modrm[5:3]] <= tail_q + ROB_W'(disp_n - 3'h1);
            end
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rec_q <= '0;
        end else if (mis_now) begin
            rec_q <= 2'(REC_CYC);
        end else if (rec_q != '0) begin
            rec_q <= rec_q - 2'h1;
        end
    end
    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_recover;
        (!fetch_req)[*3];
    endsequence
    a_rec_penalty: assert property (mis_now |=> s_recover)
        else $error("refetch before three recovery cycles");
    a_rob_bound: assert property (rcnt_q <= 5'(ROB_N))
        else $error("reorder occupancy above sixteen");
    a_alloc_room: assert property (
        disp_go |-> rob_free >= 5'(disp_n) && disp_n <= 3'(ISSUE))
        else $error("dispatch without room");
    a_tail_cut: assert property (
        mis_now |=> tail_q == $past(mis_res.rob) + 4'h1 && kill_o.v)
        else $error("wrong path not cut at branch");
    a_ret_order: assert property (ret_o.v |-> head_q == $past(head_q) + 4'h1)
        else $error("retire out of order");
    a_fast_path: assert property (
        disp_go && !microcode_rom_path |-> disp_n < 3'(ISSUE) && q_pop)
        else $error("fast path op count wrong");
    a_ucode_group: assert property (
        disp_go && microcode_rom_path && !last_grp |=> mstep_q == 4'(ISSUE))
        else $error("microcode group not advanced");
    a_queue_hold: assert property (
        fetch_valid && end_now && !q_in_ready && !flush |=> $stable(fetch_addr))
        else $error("closing byte taken with full queue");
    a_start_tag: assert property (
        q_out_valid |-> q_out.by[0].tag[T_ST] && q_out.by[q_out.len - 4'h1].tag[T_EN])
        else $error("queued instruction lacks start or end mark");
    a_issue_free: assert property (iss_o[0].v |-> $past(unit_free[0]))
        else $error("issue to busy unit");
endmodule : pdr_core

// ==== pdr_far.sv ====
`timescale 1ns/100ps
// ==========================================================
// far side: code image, six execution units, register file
module pdr_far (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // fetch
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_valid,
    output logic [7:0] fetch_byte,
    // units and register file
    input wire pdr_pkg::pdr_iss_t [5:0] iss_o,
    input wire pdr_pkg::pdr_ret_t ret_o,
    input wire pdr_pkg::pdr_kill_t kill_o,
    output logic [5:0] unit_free,
    output pdr_pkg::pdr_res_t [5:0] res_i,
    output logic [7:0][31:0] rf_data,
    // scenario control
    input wire logic [7:0] lim,
    input wire logic [5:0] slow,
    input wire logic mis_arm
);
    import pdr_pkg::*;
    logic [7:0] mem [256];
    logic [2:0] cnt_q [NUNIT];
    pdr_iss_t [NUNIT-1:0] op_q;
    assign fetch_valid = fetch_req && (fetch_addr < {24'h00, lim});
    // bytes past the image show the inverse, never a stale copy
    assign fetch_byte = fetch_valid ? mem[fetch_addr[7:0]] : ~mem[fetch_addr[7:0]];
    // busy as soon as an op shows up, so a second one is refused
    always_comb begin
        for (int u = 0; u < NUNIT; u++) unit_free[u] = cnt_q[u] == 3'h0 && !iss_o[u].v;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        for (int u = 0; u < NUNIT; u++) begin
            if (!arst_n) begin
                cnt_q[u] <= 3'h0;
                res_i[u] <= '0;
            end else begin
                res_i[u] <= '0;
                if (kill_o.v) cnt_q[u] <= 3'h0;
                else if (iss_o[u].v) begin
                    op_q[u] <= iss_o[u];
                    cnt_q[u] <= slow[u] ? 3'h6 : 3'h1;
                end else if (cnt_q[u] != 3'h0) begin
                    cnt_q[u] <= cnt_q[u] - 3'h1;
                    if (cnt_q[u] == 3'h1) res_i[u] <= '{v: 1'b1, rob: op_q[u].rob,
                        data: op_q[u].a + op_q[u].b, mis: mis_arm, taken: 1'b1,
                        bpc: '0, tgt: {24'h00, lim}};
                end
            end
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int r = 0; r < NARCH; r++) rf_data[r] <= XLEN'(32'h11 * r);
        end else if (ret_o.v) rf_data[ret_o.rg] <= ret_o.data;
    end
endmodule : pdr_far

// ==== tb_predecode_dispatch_reorder_core.sv ====
`timescale 1ns/100ps
// ==========================================================
// bench top
module tb_predecode_dispatch_reorder_core;
    import pdr_pkg::*;
    logic clk_sys, fetch_req, fetch_valid, fetch_ready, arst_n = 1'b0, mis_arm = 1'b0;
    logic [7:0] fetch_byte, lim = 8'h00, pc = 8'h00;
    logic [NUNIT-1:0] unit_free, umask, slow = '0;
    logic [XLEN-1:0] fetch_addr;
    logic [NARCH-1:0][XLEN-1:0] rf_data, rf0;
    pdr_iss_t [NUNIT-1:0] iss_o;
    pdr_res_t [NUNIT-1:0] res_i;
    pdr_ret_t ret_o;
    pdr_kill_t kill_o;
    pdr_ret_t rq [$];
    int n_errors, n_checks, n_iss;
    pdr_core u_dut (.clk_sys, .arst_n, .fetch_req, .fetch_addr, .fetch_valid, .fetch_byte,
        .fetch_ready, .rf_data, .ret_o, .unit_free, .iss_o, .res_i, .kill_o);
    pdr_far u_far (.clk_sys, .arst_n, .fetch_req, .fetch_addr, .fetch_valid, .fetch_byte,
        .iss_o, .ret_o, .kill_o, .unit_free, .res_i, .rf_data, .lim, .slow, .mis_arm);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // pulses stand one cycle, so each is seen once mid-cycle
    always @(negedge clk_sys) begin
        for (int u = 0; u < NUNIT; u++) if (iss_o[u].v === 1'b1) umask[u] = 1'b1;
        for (int u = 0; u < NUNIT; u++) n_iss += int'(iss_o[u].v === 1'b1);
        if (ret_o.v === 1'b1) rq.push_back(ret_o);
    end
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) $display("MISMATCH %0t %s", $time, m);
        n_errors += int'(ok !== 1'b1);
    endtask : chk
    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // a zero third byte means a two-byte instruction
    task automatic put(input logic [7:0] a, b, c = 8'h00);
        u_far.mem[pc] = a;
        u_far.mem[pc + 8'h01] = b;
        if (c != 8'h00) u_far.mem[pc + 8'h02] = c;
        pc = pc + ((c != 8'h00) ? 8'h03 : 8'h02);
    endtask : put
    task automatic go(input int n);
        rq.delete();
        n_iss = 0;
        umask = '0;
        rf0 = rf_data;
        @(posedge clk_sys);
        lim <= pc;
        for (int i = 0; i < 400 && rq.size() < n; i++) @(posedge clk_sys);
        if (rq.size() < n) begin
            chk(1'b0, "retire timeout");
            finish_test();
        end
        repeat (8) @(posedge clk_sys);
    endtask : go
    task automatic t_fast();
        for (int c = 1; c < 4; c++) begin
            put(8'(8'h02 + 16 * c), 8'h29);
            go(1);
            chk(n_iss == c, "fast op count");
            chk(umask === 6'(((1 << c) - 1) << 2), "fast unit choice");
            chk(rq.size() == 1 && rq[0].rg === 3'h5, "fast dest");
            if (c == 1) chk(rq[0].data === rf0[1] + rf0[5], "fast data");
        end
    endtask : t_fast
    // both groups of four land on units 2 to 5
    task automatic t_ucode();
        put(PREFIX, 8'h02, 8'h29);
        go(1);
        chk(n_iss == UCODE_OPS, "microcode op count");
        chk(umask === 6'h3c, "microcode units");
        chk(rq.size() == 1 && rq[0].rg === 3'h5, "microcode dest");
    endtask : t_ucode
    task automatic t_order();
        slow <= 6'h04;
        put(8'h12, 8'h29);
        // low nibble 3 means three bytes; the last one is filler
        put(8'h13, 8'h31, 8'h01);
        put(8'h13, 8'h35, 8'h01);
        go(3);
        chk(rq.size() == 3 && rq[0].rg === 3'h5 && rq[1].rg === 3'h6, "order");
        chk(rq[2].data === 2 * rf0[1] + rf0[5] + rf0[6], "forwarded");
        slow <= '0;
    endtask : t_order
    task automatic t_mis();
        int i;
        rq.delete();
        mis_arm <= 1'b1;
        put(8'h12, 8'h29);
        put(8'h12, 8'h31);
        @(posedge clk_sys);
        lim <= pc;
        for (i = 0; i < 300 && kill_o.v !== 1'b1; i++) @(negedge clk_sys);
        chk(fetch_req === 1'b0 && fetch_addr === XLEN'(pc), "redirect");
        repeat (2) begin
            @(negedge clk_sys);
            chk(fetch_req === 1'b0, "recovery hold");
        end
        @(negedge clk_sys);
        chk(fetch_req === 1'b1 && i < 300, "refetch");
        @(posedge clk_sys);
        mis_arm <= 1'b0;
        repeat (10) @(posedge clk_sys);
        foreach (rq[k]) chk(rq[k].rg !== 3'h6, "wrong path retired");
    endtask : t_mis
    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_fast();
        t_ucode();
        t_order();
        t_mis();
        finish_test();
    end
endmodule : tb_predecode_dispatch_reorder_core
